// File: src/pcrc_consts.vh
// Register map, field positions and reset values of the CRC generator
`ifndef PCRC_CONSTS_VH
`define PCRC_CONSTS_VH

// Register base offsets (byte addresses)
`define PCRC_OFF_CTRL 12'ha00
`define PCRC_OFF_POLY 12'ha10
`define PCRC_OFF_RES 12'ha20
`define PCRC_OFF_DIN 12'ha30
// Alias sub-offsets
`define PCRC_ALIAS_WR 2'h0
`define PCRC_ALIAS_CLR 2'h1
`define PCRC_ALIAS_SET 2'h2
`define PCRC_ALIAS_INV 2'h3

// Control register fields
`define PCRC_F_WW_HI 28
`define PCRC_F_WW_LO 24
`define PCRC_F_PL_HI 20
`define PCRC_F_PL_LO 16
`define PCRC_F_ON 15
`define PCRC_F_STOP_IN_IDLE 13
`define PCRC_F_CNT_HI 12
`define PCRC_F_CNT_LO 8
`define PCRC_F_FULL 7
`define PCRC_F_EMPTY 6
`define PCRC_F_ISEL 5
`define PCRC_F_GO 4
`define PCRC_F_LSBF 3
`define PCRC_F_MODE 2
// Software-writable control and tap bits, reset values
`define PCRC_CTRL_WMASK 32'h1f1f_a03c
`define PCRC_POLY_WMASK 32'hffff_fffe
`define PCRC_CTRL_RST 32'h0000_0000
`define PCRC_POLY_RST 32'h0000_0000
`define PCRC_RES_RST 32'h0000_0000

// FIFO geometry: 16 slots of 32 bits, usable depth follows width
`define PCRC_FIFO_SLOTS 16
`define PCRC_PTR_W 4
`define PCRC_CNT_W 5
`define PCRC_DEPTH_NARROW 5'h10
`define PCRC_DEPTH_MID 5'h08
`define PCRC_DEPTH_WIDE 5'h04
`define PCRC_WW_NARROW_MAX 5'h07
`define PCRC_WW_MID_MAX 5'h0f

// Bus responses
`define PCRC_RESP_OKAY 2'h0
`define PCRC_RESP_SLVERR 2'h2

`endif

// File: src/pcrc_fifo_mem.v
// Word store for the CRC data FIFO, registered read port
`timescale 1ns/1ps
`include "pcrc_consts.vh"

module pcrc_fifo_mem (
  input wire ref_clk,
  input wire clk_en,
  input wire wr_en,
  input wire [`PCRC_PTR_W-1:0] wr_addr,
  input wire [31:0] wr_data,
  input wire [`PCRC_PTR_W-1:0] rd_addr,
  output reg [31:0] rd_data_ff
);

  reg [31:0] mem [0:`PCRC_FIFO_SLOTS-1];

  // Write port and registered read; no reset so it maps to RAM
  always @(posedge ref_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule

// File: src/pcrc_top.v
// Programmable CRC generator with AXI4-Lite registers and data FIFO
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "pcrc_consts.vh"

module pcrc_top (
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  input wire sys_idle,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg crc_irq_ff
);

  // ----------------------------------------------------------------
  // Pin synchroniser for the idle indication
  // ----------------------------------------------------------------
  reg idle_s1_ff;
  reg idle_s2_ff;
  reg idle_s3_ff;
  reg idle_ff;

  // Three stages; idle counts once stages two and three agree
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_s1_ff <= 1'b0;
      idle_s2_ff <= 1'b0;
      idle_s3_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else if (clk_en) begin
      idle_s1_ff <= sys_idle;
      idle_s2_ff <= idle_s1_ff;
      idle_s3_ff <= idle_s2_ff;
      if (idle_s2_ff == idle_s3_ff) begin
        idle_ff <= idle_s3_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [31:0] ctrl_ff;
  reg [31:0] poly_ff;
  reg [31:0] res_ff;
  reg [31:0] din_ff;
  reg [`PCRC_PTR_W-1:0] wptr_ff;
  reg [`PCRC_PTR_W-1:0] rptr_ff;
  reg [`PCRC_CNT_W-1:0] cnt_ff;
  reg [31:0] shreg_ff;
  reg [5:0] bits_left_ff;
  reg load_pend_ff;
  reg fifo_empty_d_ff;
  reg shift_busy_d_ff;

  // Bus write channel holding registers
  reg aw_got_ff;
  reg w_got_ff;
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  wire [31:0] mem_rd_data;
  wire [4:0] word_w_m1 = ctrl_ff[`PCRC_F_WW_HI:`PCRC_F_WW_LO];
  wire [4:0] poly_l_m1 = ctrl_ff[`PCRC_F_PL_HI:`PCRC_F_PL_LO];
  wire lsb_first = ctrl_ff[`PCRC_F_LSBF];
  wire go_bit = ctrl_ff[`PCRC_F_GO];

  wire [`PCRC_CNT_W-1:0] depth = (word_w_m1 <= `PCRC_WW_NARROW_MAX) ? `PCRC_DEPTH_NARROW :
    (word_w_m1 <= `PCRC_WW_MID_MAX) ? `PCRC_DEPTH_MID : `PCRC_DEPTH_WIDE;
  wire fifo_full = (cnt_ff >= depth);
  wire fifo_empty = (cnt_ff == {`PCRC_CNT_W{1'b0}});

  wire run = ctrl_ff[`PCRC_F_ON] & ~(ctrl_ff[`PCRC_F_STOP_IN_IDLE] & idle_ff);
  // shifter active only while start set
  wire shift_on = run & go_bit;

  // ----------------------------------------------------------------
  // Bus write decode
  // ----------------------------------------------------------------
  wire wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire [11:0] wr_base = {awaddr_ff[11:4], 4'h0};
  wire [1:0] wr_alias = awaddr_ff[3:2];
  wire [31:0] strb_mask;
  wire wr_ctrl = wr_fire & (wr_base == `PCRC_OFF_CTRL);
  wire wr_poly = wr_fire & (wr_base == `PCRC_OFF_POLY);
  wire wr_res = wr_fire & (wr_base == `PCRC_OFF_RES);
  wire wr_din = wr_fire & (wr_base == `PCRC_OFF_DIN);
  wire wr_hit = wr_ctrl | wr_poly | wr_res | wr_din;

  // Byte enables spread to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_strb
      assign strb_mask[gi*8+7:gi*8] = {8{wstrb_ff[gi]}};
    end
  endgenerate

  function [31:0] alias_apply;
    input [31:0] cur;
    input [31:0] val;
    input [31:0] msk;
    input [1:0] kind;
    begin
      case (kind)
        `PCRC_ALIAS_WR: alias_apply = (cur & ~msk) | (val & msk);
        `PCRC_ALIAS_CLR: alias_apply = cur & ~(val & msk);
        `PCRC_ALIAS_SET: alias_apply = cur | (val & msk);
        `PCRC_ALIAS_INV: alias_apply = cur ^ (val & msk);
        default: alias_apply = cur;
      endcase
    end
  endfunction

  wire [31:0] din_new = alias_apply(din_ff, wdata_ff, strb_mask, wr_alias);
  // word pushed when the FIFO accepts it
  wire push = wr_din & ~fifo_full;
  // Pop into shifter: engine running, shifter idle, data waiting
  wire pop = shift_on & ~fifo_empty & (bits_left_ff == 6'h00) & ~load_pend_ff;
  wire shift_busy = load_pend_ff | (bits_left_ff != 6'h00);

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  // Address and data latched independently, either order
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCRC_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_got_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_got_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PCRC_RESP_OKAY : `PCRC_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  // Read channel: one-cycle ready, data registered next cycle
  wire [11:0] rd_base = {s_axi_araddr[11:4], 4'h0};
  reg [31:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_hit = 1'b1;
    case (rd_base)
      `PCRC_OFF_CTRL: rd_mux = (ctrl_ff & `PCRC_CTRL_WMASK)
        | ({27'h0, cnt_ff} << `PCRC_F_CNT_LO)
        | ({31'h0, fifo_full} << `PCRC_F_FULL)
        | ({31'h0, fifo_empty} << `PCRC_F_EMPTY);
      `PCRC_OFF_POLY: rd_mux = poly_ff & `PCRC_POLY_WMASK;
      `PCRC_OFF_RES: rd_mux = res_ff;
      `PCRC_OFF_DIN: rd_mux = din_ff;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Reads answer one cycle after address accepted
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PCRC_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `PCRC_RESP_OKAY : `PCRC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  wire [31:0] ctrl_new = alias_apply(ctrl_ff, wdata_ff, strb_mask, wr_alias);
  wire [31:0] poly_new = alias_apply(poly_ff, wdata_ff, strb_mask, wr_alias);

  // fields stored; write mask drops unused bits
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `PCRC_CTRL_RST;
      poly_ff <= `PCRC_POLY_RST;
      din_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_ff <= ctrl_new & `PCRC_CTRL_WMASK;
      end
      if (wr_poly) begin
        poly_ff <= poly_new & `PCRC_POLY_WMASK;
      end
      if (wr_din) begin
        din_ff <= din_new;
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO pointers and count
  // ----------------------------------------------------------------
  // count tracks pushes and pops
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr_ff <= {`PCRC_PTR_W{1'b0}};
      rptr_ff <= {`PCRC_PTR_W{1'b0}};
      cnt_ff <= {`PCRC_CNT_W{1'b0}};
    end else if (clk_en) begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  pcrc_fifo_mem u_mem (
    .ref_clk(ref_clk),
    .clk_en(clk_en),
    .wr_en(push),
    .wr_addr(wptr_ff),
    .wr_data(din_new),
    .rd_addr(rptr_ff),
    .rd_data_ff(mem_rd_data)
  );

  // ----------------------------------------------------------------
  // Serial shifter and CRC state
  // ----------------------------------------------------------------
  // Next input bit follows the shift order
  wire in_bit = lsb_first ? shreg_ff[0] : shreg_ff[word_w_m1];
  wire fb = in_bit ^ res_ff[poly_l_m1];
  wire [31:0] len_mask = {32{1'b1}} >> (5'd31 - poly_l_m1);
  wire [31:0] crc_step = ({res_ff[30:0], 1'b0} ^ ({32{fb}} & poly_ff)) & len_mask;
  wire [31:0] res_new = alias_apply(res_ff, wdata_ff, strb_mask, wr_alias);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_ff <= `PCRC_RES_RST;
      shreg_ff <= 32'h0000_0000;
      bits_left_ff <= 6'h00;
      load_pend_ff <= 1'b0;
    end else if (clk_en) begin
      // clearing start aborts shifting in progress
      if (!shift_on) begin
        bits_left_ff <= 6'h00;
        load_pend_ff <= 1'b0;
      end else if (pop) begin
        load_pend_ff <= 1'b1;
      end else if (load_pend_ff) begin
        load_pend_ff <= 1'b0;
        shreg_ff <= mem_rd_data;
        bits_left_ff <= {1'b0, word_w_m1} + 6'h01;
      end else if (bits_left_ff != 6'h00) begin
        shreg_ff <= lsb_first ? {1'b0, shreg_ff[31:1]} : {shreg_ff[30:0], 1'b0};
        bits_left_ff <= bits_left_ff - 6'h01;
        res_ff <= crc_step;
      end
      // software seed preload wins over shifting
      if (wr_res) begin
        res_ff <= res_new;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt event
  // ----------------------------------------------------------------
  // One-cycle pulse on the chosen condition's rising edge
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_empty_d_ff <= 1'b1;
      shift_busy_d_ff <= 1'b0;
      crc_irq_ff <= 1'b0;
    end else if (clk_en) begin
      fifo_empty_d_ff <= fifo_empty;
      shift_busy_d_ff <= shift_busy | ~fifo_empty;
      if (ctrl_ff[`PCRC_F_ISEL]) begin
        // FIFO just drained, last word still shifting
        crc_irq_ff <= run & fifo_empty & ~fifo_empty_d_ff;
      end else begin
        crc_irq_ff <= run & ~(shift_busy | ~fifo_empty) & shift_busy_d_ff;
      end
    end
  end

endmodule

// File: test/pcrc_checker.sv
// Port checker for the CRC generator, bound to its top module
`timescale 1ns/1ps
`include "pcrc_consts.vh"

module pcrc_checker (
  input wire ref_clk,
  input wire reset_n,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire crc_irq_ff
);
  reg [11:0] rd_addr_ff;
  wire [4:0] cnt = s_axi_rdata[12:8];
  wire [4:0] ww = s_axi_rdata[28:24];
  // Depth follows the width field read in the same word
  wire [4:0] dep = (ww <= 5'h07) ? 5'h10 : (ww <= 5'h0f) ? 5'h08 : 5'h04;
  wire ctl_rd = s_axi_rvalid && rd_addr_ff == 12'ha00;
  wire poly_rd = s_axi_rvalid && rd_addr_ff == 12'ha10;
  wire bad_rd = s_axi_rvalid && (rd_addr_ff < 12'ha00 || rd_addr_ff > 12'ha3f);

  // Address of the read under way; only one read is outstanding
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rd_addr_ff <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_ff <= s_axi_araddr;
  end

  // ------------------------------------------------------------
  // Read data and interrupt pulse against status rules
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_ctl_rsvd_zero: assert property (ctl_rd |-> (s_axi_rdata & 32'he0e0_4003) == 32'h0)
    else $error("control reserved bits not zero");
  a_poly_bit0_zero: assert property (poly_rd |-> !s_axi_rdata[0])
    else $error("tap bit zero set");
  a_empty_flag: assert property (ctl_rd |-> s_axi_rdata[6] == (cnt == 5'h00))
    else $error("empty flag disagrees with count");
  a_full_flag: assert property (ctl_rd |-> s_axi_rdata[7] == (cnt == dep))
    else $error("full flag disagrees with count");
  a_count_depth: assert property (ctl_rd |-> cnt <= dep)
    else $error("word count above depth");
  a_full_not_empty: assert property (ctl_rd |-> !(s_axi_rdata[7] && s_axi_rdata[6]))
    else $error("full and empty together");
  a_unmapped_err: assert property (bad_rd |-> s_axi_rresp == `PCRC_RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  a_irq_pulse: assert property (crc_irq_ff |=> !crc_irq_ff)
    else $error("interrupt longer than one cycle");
endmodule

bind pcrc_top pcrc_checker chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .crc_irq_ff(crc_irq_ff));

// File: test/tb_top.sv
// Self-checking bench for the CRC generator over AXI4-Lite
`timescale 1ns/1ps
`include "pcrc_consts.vh"

module tb_top;
  logic ref_clk, reset_n, clk_en, sys_idle;
  logic [11:0] aw_a, ar_a;
  logic aw_v, w_v, b_r, ar_v, r_r;
  logic [31:0] w_d, ctl, e;
  logic [3:0] w_s;
  wire aw_r, w_r, b_v, ar_r, r_v, irq;
  wire [1:0] b_p, r_p;
  wire [31:0] r_d;
  int miscompares, n_checks, irqs, s, dep, c;
  logic [4:0] wtab [5] = '{5'd7, 5'd8, 5'd15, 5'd16, 5'd31};

  pcrc_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .sys_idle(sys_idle),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_p),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_p), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .crc_irq_ff(irq));

  // ------------------------------------------------------------
  // Clock, interrupt counter and helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Each high cycle of the interrupt is one event
  always @(posedge ref_clk) begin
    if (irq === 1'b1) irqs++;
  end

  task automatic finish_test;
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait; a hang ends the run
  task automatic limit(inout int n);
    n++;
    if (n > 3000) begin
      chk("wait bound", 32'h1, 32'h0);
      finish_test();
    end
  endtask

  // Address and data offered together; one idle edge after so ready never toggles twice
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit ad, wd;
    n = 0;
    ad = 0;
    wd = 0;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      ad |= aw_r;
      wd |= w_r;
      limit(n);
    end
    do begin
      @(posedge ref_clk);
      limit(n);
    end while (b_v !== 1'b1);
    b_r <= 1'b0;
    chk($sformatf("bresp %h", a), {30'h0, b_p}, {30'h0, er});
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge ref_clk);
      limit(n);
    end while (ar_r !== 1'b1);
    ar_v <= 1'b0;
    do begin
      @(posedge ref_clk);
      limit(n);
    end while (r_v !== 1'b1);
    r_r <= 1'b0;
    chk($sformatf("rdata %h", a), r_d, ed);
    chk($sformatf("rresp %h", a), {30'h0, r_p}, {30'h0, er});
    @(posedge ref_clk);
  endtask

  task automatic wirq;
    int n;
    n = 0;
    s = irqs;
    while (irqs == s) begin
      @(posedge ref_clk);
      limit(n);
    end
  endtask

  // Reference CRC, 16-bit words and length, taps 0x1020
  function automatic logic [31:0] crc_f(input logic [31:0] r, input logic [15:0] d, input bit lsb);
    logic fb;
    for (int i = 0; i < 16; i++) begin
      fb = (lsb ? d[i] : d[15 - i]) ^ r[15];
      r = ((r << 1) ^ (fb ? 32'h1020 : 32'h0)) & 32'hffff;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    sys_idle = 1'b0;
    {aw_a, ar_a, aw_v, w_v, b_r, ar_v, r_r, w_d} = '0;
    w_s = 4'hf;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(12'ha00, 32'h0000_0040, 2'h0);
    rd(12'ha10, 32'h0, 2'h0);
    rd(12'ha20, 32'h0, 2'h0);
    wr(12'ha00, 32'hffff_ffff, 2'h0);
    rd(12'ha00, 32'h1f1f_a07c, 2'h0);
    wr(12'ha00, 32'h0, 2'h0);
    wr(12'ha10, 32'hffff_ffff, 2'h0);
    rd(12'ha10, 32'hffff_fffe, 2'h0);
    wr(12'ha14, 32'hffff_ff0f, 2'h0);
    rd(12'ha10, 32'h0000_00f0, 2'h0);
    wr(12'ha18, 32'h0000_000f, 2'h0);
    rd(12'ha10, 32'h0000_00fe, 2'h0);
    wr(12'ha1c, 32'h0000_0033, 2'h0);
    rd(12'ha10, 32'h0000_00cc, 2'h0);
    // Only byte one enabled: other bytes keep their taps
    w_s <= 4'h2;
    wr(12'ha10, 32'hffff_ffff, 2'h0);
    w_s <= 4'hf;
    rd(12'ha10, 32'h0000_ffcc, 2'h0);
    wr(12'h100, 32'h1234_5678, 2'h2);
    rd(12'h100, 32'h0, 2'h2);
    // Fill past depth at each width boundary, then drain
    foreach (wtab[i]) begin
      ctl = {3'h0, wtab[i], 8'h0, 16'h8000};
      wr(12'ha00, ctl, 2'h0);
      dep = (wtab[i] <= 7) ? 16 : (wtab[i] <= 15) ? 8 : 4;
      for (int k = 1; k <= dep + 1; k++) begin
        wr(12'ha30, k, 2'h0);
        c = (k > dep) ? dep : k;
        rd(12'ha00, ctl | (c << 8) | ((c == dep) << 7), 2'h0);
      end
      wr(12'ha08, 32'h10, 2'h0);
      wirq();
      wr(12'ha04, 32'h10, 2'h0);
      rd(12'ha00, ctl | 32'h40, 2'h0);
    end
    // Both bit orders, each with its own interrupt source
    for (int m = 0; m < 2; m++) begin
      wr(12'ha10, 32'h0000_1020, 2'h0);
      wr(12'ha20, 32'h0000_ffff, 2'h0);
      wr(12'ha00, 32'h0f0f_8000 | (m << 5) | (m << 3), 2'h0);
      wr(12'ha30, 32'h0000_a55a, 2'h0);
      wr(12'ha30, 32'h0000_0f0f, 2'h0);
      wr(12'ha08, 32'h10, 2'h0);
      // Clock enable low freezes the shifter with the first word loaded, before its first shift
      s = irqs;
      clk_en <= 1'b0;
      repeat (100) @(posedge ref_clk);
      chk("interrupt while frozen", irqs - s, 32'h0);
      clk_en <= 1'b1;
      wirq();
      repeat (40) @(posedge ref_clk);
      chk("interrupt count", irqs - s, 32'h1);
      e = crc_f(crc_f(32'hffff, 16'ha55a, m), 16'h0f0f, m);
      rd(12'ha20, e, 2'h0);
      wr(12'ha04, 32'h10, 2'h0);
    end
    // Idle halts the shifter until idle ends
    sys_idle <= 1'b1;
    wr(12'ha20, 32'h0000_ffff, 2'h0);
    wr(12'ha00, 32'h0f0f_a010, 2'h0);
    wr(12'ha30, 32'h0000_1234, 2'h0);
    repeat (50) @(posedge ref_clk);
    rd(12'ha20, 32'h0000_ffff, 2'h0);
    sys_idle <= 1'b0;
    wirq();
    e = crc_f(32'hffff, 16'h1234, 0);
    rd(12'ha20, e, 2'h0);
    // Disabled engine leaves the result alone
    wr(12'ha00, 32'h0f0f_0010, 2'h0);
    wr(12'ha30, 32'h0000_4321, 2'h0);
    repeat (50) @(posedge ref_clk);
    rd(12'ha20, e, 2'h0);
    finish_test();
  end
endmodule
